// ===== pwm_auto_shutdown.sv
// Purpose: Auto-shutdown of the four PWM output pins with APB control
// Assumes: PWM levels, mode flag and period flag come from the same clock
// Notes:   Raw sources gate the pins combinationally; status uses synced copies
//          Control at 0x00: [7] status, [6:4] source, [3:2] a/c, [1:0] b/d
//          Irq status at 0x04 is read only: [0] shutdown, [1] resumed
//          Irq enable at 0x08 has the status layout
//          Irq clear at 0x0c is write only; a one clears that bit
//          Unmapped offsets raise pslverr and read as zero
//          Ready follows clk_en, so no wait states while enabled
//          Release from shutdown waits for the next period start
//          Select codes 000 and 111 ignore every source

`timescale 1ns/1ps
`default_nettype none

module pwm_auto_shutdown (
    input  wire logic                            clock,
    input  wire logic                            nrst,
    input  wire logic                            clk_en,
    // APB slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [7:0]                      paddr,
    input  wire logic [31:0]                     pwdata,
    output logic [31:0]                          prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // PWM unit side
    input  wire logic [3:0]                      pwm_level,
    input  wire logic                            pwm_mode_active,
    input  wire logic                            period_timer_flag,
    input  wire logic                            external_irq_zero_enable,
    // Asynchronous shutdown sources
    input  wire pwm_shutdown_pkg::shutdown_src_t shutdown_src,
    // Pins a, b, c, d
    output pwm_shutdown_pkg::pin_drive_t         pwm_out,
    output logic                                 irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pwm_shutdown_pkg::shutdown_ctrl_t ctrl_q, ctrl_d;
    pwm_shutdown_pkg::shutdown_src_t  src_meta_q, src_sync_q;
    pwm_shutdown_pkg::run_state_t     state_q, state_d;
    logic [1:0]                       irq_status_q, irq_status_d;
    logic [1:0]                       irq_enable_q, irq_enable_d;
    logic [31:0]                      prdata_q, prdata_d;

    logic                             raw_hit;
    logic                             sync_hit;
    logic                             hw_event;
    logic                             setup;
    logic                             access;
    logic                             wr;
    logic                             mapped;
    logic                             force_shutdown;
    logic                             resume;
    logic                             wr_ctrl;
    logic                             wr_irq_enable;
    logic                             wr_irq_clear;
    logic                             irq_d;

    // ------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------
    // Raw path keeps the pin response independent of the clock
    shutdown_source_mux raw_mux (
        .src                      (shutdown_src),
        .source_select            (ctrl_q.shutdown_source_select),
        .external_irq_zero_enable (external_irq_zero_enable),
        .hit                      (raw_hit)
    );

    shutdown_source_mux sync_mux (
        .src                      (src_sync_q),
        .source_select            (ctrl_q.shutdown_source_select),
        .external_irq_zero_enable (external_irq_zero_enable),
        .hit                      (sync_hit)
    );

    // ------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------
    // Second stage feeds the status path and the hold release check
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            src_meta_q <= '0;
            src_sync_q <= '0;
        end else if (clk_en) begin
            src_meta_q <= shutdown_src;
            src_sync_q <= src_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == pwm_shutdown_pkg::CTRL_OFFSET)
                  | (addr == pwm_shutdown_pkg::IRQ_STATUS_OFFSET)
                  | (addr == pwm_shutdown_pkg::IRQ_ENABLE_OFFSET)
                  | (addr == pwm_shutdown_pkg::IRQ_CLEAR_OFFSET);
    endfunction

    // Write strobe for one register
    function automatic logic wr_to(input logic       strobe,
                                   input logic [7:0] addr,
                                   input logic [7:0] offset);
        wr_to = strobe & (addr == offset);
    endfunction

    always_comb begin
        setup   = psel & ~penable;
        access  = psel & penable & clk_en;
        mapped  = is_mapped(paddr);
        wr      = access & pwrite & mapped;
        pready  = clk_en;
        pslverr = psel & penable & ~mapped;
        prdata  = prdata_q;
    end

    // ------------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------------
    always_comb begin
        wr_ctrl       = wr_to(wr, paddr, pwm_shutdown_pkg::CTRL_OFFSET);
        wr_irq_enable = wr_to(wr, paddr, pwm_shutdown_pkg::IRQ_ENABLE_OFFSET);
        wr_irq_clear  = wr_to(wr, paddr, pwm_shutdown_pkg::IRQ_CLEAR_OFFSET);
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Captured in the setup cycle, so it stands through the access
    always_comb begin
        prdata_d = prdata_q;
        if (setup) begin
            prdata_d = '0;
            unique case (paddr)
                pwm_shutdown_pkg::CTRL_OFFSET:
                    prdata_d[pwm_shutdown_pkg::CTRL_WIDTH-1:0] = ctrl_q;
                pwm_shutdown_pkg::IRQ_STATUS_OFFSET:
                    prdata_d[pwm_shutdown_pkg::IRQ_WIDTH-1:0] = irq_status_q;
                pwm_shutdown_pkg::IRQ_ENABLE_OFFSET:
                    prdata_d[pwm_shutdown_pkg::IRQ_WIDTH-1:0] = irq_enable_q;
                default:
                    prdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata_q <= '0;
        end else if (clk_en) begin
            prdata_q <= prdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_comb begin
        hw_event = pwm_mode_active & sync_hit;
        ctrl_d   = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = pwdata[pwm_shutdown_pkg::CTRL_WIDTH-1:0];
        end
        if (hw_event) begin
            ctrl_d.shutdown_event_status = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= pwm_shutdown_pkg::CTRL_RESET;
        end else if (clk_en) begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------------
    // Run / hold sequencing
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        resume  = 1'b0;
        unique case (state_q)
            pwm_shutdown_pkg::RUN: begin
                if (ctrl_q.shutdown_event_status) begin
                    state_d = pwm_shutdown_pkg::HOLD;
                end
            end
            pwm_shutdown_pkg::HOLD: begin
                // Release only at a period start, so a whole period is kept
                if (period_timer_flag && !ctrl_q.shutdown_event_status
                    && !sync_hit) begin
                    state_d = pwm_shutdown_pkg::RUN;
                    resume  = 1'b1;
                end
            end
            default: begin
                state_d = pwm_shutdown_pkg::HOLD;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= pwm_shutdown_pkg::RUN;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_comb begin
        irq_status_d = irq_status_q;
        irq_enable_d = irq_enable_q;
        if (wr_irq_clear) begin
            irq_status_d = irq_status_q & ~pwdata[pwm_shutdown_pkg::IRQ_WIDTH-1:0];
        end
        if (wr_irq_enable) begin
            irq_enable_d = pwdata[pwm_shutdown_pkg::IRQ_WIDTH-1:0];
        end
        // Set wins over a clear in the same cycle
        if (ctrl_d.shutdown_event_status && !ctrl_q.shutdown_event_status) begin
            irq_status_d[pwm_shutdown_pkg::IRQ_SHUTDOWN_BIT] = 1'b1;
        end
        if (resume) begin
            irq_status_d[pwm_shutdown_pkg::IRQ_RESUME_BIT] = 1'b1;
        end
        irq_d = |(irq_status_d & irq_enable_d);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_status_q <= pwm_shutdown_pkg::IRQ_RESET;
            irq_enable_q <= pwm_shutdown_pkg::IRQ_RESET;
            irq          <= 1'b0;
        end else if (clk_en) begin
            irq_status_q <= irq_status_d;
            irq_enable_q <= irq_enable_d;
            irq          <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Pin gating
    // ------------------------------------------------------------------
    always_comb begin
        force_shutdown = pwm_mode_active
                       & (raw_hit | ctrl_q.shutdown_event_status
                          | (state_q == pwm_shutdown_pkg::HOLD));
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------

    function automatic logic [1:0] pin_drive(input logic [1:0] safe_state,
                                             input logic       forced,
                                             input logic       level,
                                             input logic       mode);
        // Returns {level, enable}
        if (!forced) begin
            pin_drive = {level & mode, mode};
        end else if (safe_state[pwm_shutdown_pkg::STATE_TRI_BIT]) begin
            pin_drive = 2'b00;
        end else begin
            pin_drive = {safe_state == pwm_shutdown_pkg::STATE_HIGH, 1'b1};
        end
    endfunction

    always_comb begin
        logic [1:0] d;
        d = 2'b00;
        pwm_out = '0;
        for (int i = 0; i < pwm_shutdown_pkg::PIN_COUNT; i++) begin
            d = pin_drive((i % 2 == 0) ? ctrl_q.pins_ac_shutdown_state
                                       : ctrl_q.pins_bd_shutdown_state,
                          force_shutdown, pwm_level[i], pwm_mode_active);
            pwm_out.level[i]  = d[1];
            pwm_out.enable[i] = d[0];
        end
    end

endmodule

`default_nettype wire

// ===== pwm_auto_shutdown_chk.sv
// Purpose: Port-level assertions for the PWM auto-shutdown block
// Assumes: Control and irq enable are shadowed from APB writes
// Notes:   States 1x leave a forced pin undriven at the ports
`timescale 1ns/1ps
`default_nettype none
module pwm_auto_shutdown_chk (
    input wire logic                            clock,
    input wire logic                            nrst,
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic [7:0]                      paddr,
    input wire logic [31:0]                     pwdata,
    input wire logic                            pready,
    input wire logic                            pwm_mode_active,
    input wire logic                            period_timer_flag,
    input wire logic                            external_irq_zero_enable,
    input wire pwm_shutdown_pkg::shutdown_src_t shutdown_src,
    input wire pwm_shutdown_pkg::pin_drive_t    pwm_out,
    input wire logic                            irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // ------
    // Shadow of software fields
    // ------
    logic [6:0] ctrl_q;
    logic [1:0] ie_q;
    logic       wr;
    logic       hit;
    logic       off;
    assign wr  = psel && penable && pready && pwrite;
    assign off = pwm_mode_active && pwm_out.enable != 4'hf;
    assign hit = ctrl_q[6:4] != 3'h7 && (ctrl_q[4] && shutdown_src.comparator_1
               || ctrl_q[5] && shutdown_src.comparator_2
               || ctrl_q[6] && shutdown_src.external_irq_zero && external_irq_zero_enable);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= 7'h00;
            ie_q   <= 2'h0;
        end else if (wr && paddr == 8'h00) begin
            ctrl_q <= pwdata[6:0];
        end else if (wr && paddr == 8'h08) begin
            ie_q <= pwdata[1:0];
        end
    end
    // ------
    // Properties
    // ------
    sequence s_man_wr;
        wr && paddr == 8'h00 && pwdata[7] && pwm_mode_active;
    endsequence
    sequence s_off_end;
        pwm_mode_active && $past(pwm_mode_active) && $past(off) && !off;
    endsequence
    property p_mode_off;
        !pwm_mode_active |-> pwm_out.enable == 4'h0;
    endproperty
    property p_force_ac;
        pwm_mode_active && hit |-> {pwm_out.enable[2], pwm_out.enable[0]} == {2{!ctrl_q[3]}}
            && (ctrl_q[3] || {pwm_out.level[2], pwm_out.level[0]} == {2{ctrl_q[2]}});
    endproperty
    property p_force_bd;
        pwm_mode_active && hit |-> {pwm_out.enable[3], pwm_out.enable[1]} == {2{!ctrl_q[1]}}
            && (ctrl_q[1] || {pwm_out.level[3], pwm_out.level[1]} == {2{ctrl_q[0]}});
    endproperty
    property p_release;
        s_off_end |-> $past(period_timer_flag);
    endproperty
    property p_hold;
        $fell(hit) && $past(pwm_mode_active) && pwm_mode_active && ctrl_q[3]
            |-> !pwm_out.enable[0];
    endproperty
    property p_manual;
        s_man_wr |=> !pwm_mode_active || pwm_out.enable[0] == !ctrl_q[3]
            && (ctrl_q[3] || pwm_out.level[0] == ctrl_q[2]);
    endproperty
    property p_irq_rise;
        $rose(irq) |-> ie_q != 2'h0 || $past(ie_q) != 2'h0;
    endproperty
    property p_irq_fall;
        $fell(irq) |-> $past(wr) || $past(wr, 2);
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("pins enabled outside PWM mode");
    a_force_ac: assert property (p_force_ac)
        else $error("pins a c not in shutdown state");
    a_force_bd: assert property (p_force_bd)
        else $error("pins b d not in shutdown state");
    a_release: assert property (p_release)
        else $error("pins resumed away from period start");
    a_hold: assert property (p_hold)
        else $error("pins resumed when source dropped");
    a_manual: assert property (p_manual)
        else $error("manual shutdown not applied");
    a_irq_rise: assert property (p_irq_rise)
        else $error("irq raised while all enables clear");
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without software write");
endmodule
bind pwm_auto_shutdown pwm_auto_shutdown_chk pwm_auto_shutdown_chk_i (.clock, .nrst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pwm_mode_active, .period_timer_flag,
    .external_irq_zero_enable, .shutdown_src, .pwm_out, .irq);
`default_nettype wire

// ===== pwm_far_side.sv
// Purpose: Far-side model: comparators, irq pin and PWM period timer
// Assumes: Source levels are commanded by the bench
// Notes:   Period flag is a one-cycle pulse every 32 cycles
`timescale 1ns/1ps
`default_nettype none
module pwm_far_side (
    input  wire logic                       clock,
    input  wire logic                       nrst,
    input  wire logic [2:0]                 trip,
    output pwm_shutdown_pkg::shutdown_src_t src,
    output logic [3:0]                      level,
    output logic                            period_flag
);
    // ------
    // Period timer and level pattern
    // ------
    logic [4:0] cnt_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            cnt_q <= 5'h00;
        else
            cnt_q <= cnt_q + 5'h01;
    end
    assign period_flag = (cnt_q == 5'h1f);
    assign level       = {cnt_q[4], ~cnt_q[4], cnt_q[3], ~cnt_q[3]};
    assign src         = trip;
endmodule
`default_nettype wire

// ===== pwm_shutdown_pkg.sv
// Purpose: Shared constants and carrier types for the PWM auto-shutdown block
// Assumes: APB register bus, 32-bit data, one register per aligned word
// Notes:   Pin index order is a, b, c, d

`default_nettype none

package pwm_shutdown_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET       = 8'h00;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h0c;
    localparam int         ADDR_WIDTH        = 8;
    localparam int         DATA_WIDTH        = 32;

    // ------------------------------------------------------------------
    // Control register fields and reset value
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET        = 8'h00;
    localparam int         CTRL_WIDTH        = 8;
    localparam int         STATUS_BIT        = 7;
    localparam int         SEL_LSB           = 4;
    localparam int         AC_LSB            = 2;
    localparam int         BD_LSB            = 0;

    localparam logic [2:0] SEL_NONE          = 3'h0;
    localparam logic [2:0] SEL_CMP1          = 3'h1;
    localparam logic [2:0] SEL_CMP2          = 3'h2;
    localparam logic [2:0] SEL_CMP_ANY       = 3'h3;
    localparam logic [2:0] SEL_IRQ           = 3'h4;
    localparam logic [2:0] SEL_IRQ_CMP1      = 3'h5;
    localparam logic [2:0] SEL_IRQ_CMP2      = 3'h6;

    localparam logic [1:0] STATE_LOW         = 2'h0;
    localparam logic [1:0] STATE_HIGH        = 2'h1;
    localparam int         STATE_TRI_BIT     = 1;

    // ------------------------------------------------------------------
    // Interrupt status layout
    // ------------------------------------------------------------------
    localparam int         IRQ_WIDTH         = 2;
    localparam int         IRQ_SHUTDOWN_BIT  = 0;
    localparam int         IRQ_RESUME_BIT    = 1;
    localparam logic [1:0] IRQ_RESET         = 2'h0;

    localparam int         PIN_COUNT         = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       shutdown_event_status;
        logic [2:0] shutdown_source_select;
        logic [1:0] pins_ac_shutdown_state;
        logic [1:0] pins_bd_shutdown_state;
    } shutdown_ctrl_t;

    typedef struct packed {
        logic comparator_1;
        logic comparator_2;
        logic external_irq_zero;
    } shutdown_src_t;

    typedef struct packed {
        logic [3:0] level;
        logic [3:0] enable;
    } pin_drive_t;

    typedef enum logic [1:0] {
        RUN  = 2'b01,
        HOLD = 2'b10
    } run_state_t;

endpackage

`default_nettype wire

// ===== shutdown_source_mux.sv
// Purpose: Selects which shutdown sources may trip the PWM outputs
// Assumes: Purely combinational; usable on raw or synchronised sources
// Notes:   Codes 000 and 111 select nothing

`timescale 1ns/1ps
`default_nettype none

module shutdown_source_mux (
    input  wire pwm_shutdown_pkg::shutdown_src_t src,
    input  wire logic [2:0]                      source_select,
    input  wire logic                            external_irq_zero_enable,
    output logic                                 hit
);

    logic irq_ok;

    always_comb begin
        irq_ok = src.external_irq_zero & external_irq_zero_enable;
        unique case (source_select)
            pwm_shutdown_pkg::SEL_CMP1:     hit = src.comparator_1;
            pwm_shutdown_pkg::SEL_CMP2:     hit = src.comparator_2;
            pwm_shutdown_pkg::SEL_CMP_ANY:  hit = src.comparator_1 | src.comparator_2;
            pwm_shutdown_pkg::SEL_IRQ:      hit = irq_ok;
            pwm_shutdown_pkg::SEL_IRQ_CMP1: hit = irq_ok | src.comparator_1;
            pwm_shutdown_pkg::SEL_IRQ_CMP2: hit = irq_ok | src.comparator_2;
            default:                        hit = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// ===== tb_top.sv
// Purpose: Self-checking bench for the PWM auto-shutdown block
// Assumes: APB answers when pready is high; clk_en low only in t_freeze
// Notes:   Far-side model supplies sources, levels and period flag
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clock = 1'b0, nrst = 1'b0, clk_en = 1'b1, mode = 1'b1, ext_en = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, irq, pflag, se;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  lvl;
    logic [2:0]  trip = 3'h0;
    int          miscompares = 0, checked = 0;
    pwm_shutdown_pkg::shutdown_src_t src;
    pwm_shutdown_pkg::pin_drive_t    pout;
    always #5 clock = ~clock;
    pwm_far_side pwm_far_side_i (.clock, .nrst, .trip, .src, .level(lvl), .period_flag(pflag));
    pwm_auto_shutdown pwm_auto_shutdown_i (.clock, .nrst, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pwm_level(lvl), .pwm_mode_active(mode),
        .period_timer_flag(pflag), .external_irq_zero_enable(ext_en), .shutdown_src(src),
        .pwm_out(pout), .irq);
    // ------
    // Shared tasks
    // ------
    task automatic print_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) begin
            miscompares++;
            print_verdict();
        end
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_period(input bit held);
        int n;
        n = 0;
        do begin
            if (held)
                #1 chk("pins held", 32'h0, {28'h0, pout.enable});
            @(posedge clock);
        end while (pflag !== 1'b1 && ++n < 80);
        if (n >= 80) begin
            miscompares++;
            print_verdict();
        end
        #1 chk("pins resumed", {24'h0, lvl, 4'hf}, {24'h0, pout});
    endtask
    // ------
    // Scenarios
    // ------
    task automatic t_regs;
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b1, 8'h04, 32'h3);
        apb(1'b0, 8'h04, 32'h0);
        chk("status read only", 32'h0, rd);
        apb(1'b1, 8'h00, 32'h7f);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl readback", 32'h7f, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, se});
    endtask
    task automatic t_sources;
        logic [2:0] s;
        logic       h;
        for (int k = 0; k < 24; k++) begin
            s = 3'(k / 3);
            h = (k % 3 == 0 && s inside {1, 3, 5}) || (k % 3 == 1 && s inside {2, 3, 6})
                || (k % 3 == 2 && s inside {4, 5, 6});
            apb(1'b1, 8'h00, {25'h0, s, 4'b1001});
            @(posedge clock);
            trip <= 3'h4 >> (k % 3);
            #1 chk("pins on trip", {24'h0, h ? 8'haa : {lvl, 4'hf}},
                   {24'h0, pout.level & pout.enable, pout.enable});
            repeat (5) @(posedge clock);
            apb(1'b0, 8'h00, 32'h0);
            chk("status on trip", {24'h0, h, s, 4'b1001}, rd);
            trip <= 3'h0;
            apb(1'b1, 8'h00, {25'h0, s, 4'b1001});
            wait_period(1'b0);
        end
    endtask
    task automatic t_gate;
        ext_en <= 1'b0;
        apb(1'b1, 8'h00, 32'h49);
        trip <= 3'h1;
        repeat (5) @(posedge clock);
        apb(1'b0, 8'h00, 32'h0);
        chk("gated external source", 32'h49, rd);
        trip   <= 3'h0;
        ext_en <= 1'b1;
    endtask
    task automatic t_hold;
        apb(1'b1, 8'h00, 32'h1a);
        trip <= 3'h4;
        repeat (5) @(posedge clock);
        apb(1'b1, 8'h00, 32'h1a);
        apb(1'b0, 8'h00, 32'h0);
        chk("set wins over clear", 32'h9a, rd);
        trip <= 3'h0;
        repeat (4) @(posedge clock);
        apb(1'b1, 8'h00, 32'h1a);
        wait_period(1'b1);
    endtask
    task automatic t_manual;
        apb(1'b1, 8'h00, 32'h84);
        #1 chk("manual shutdown", 32'h5f, {24'h0, pout});
        apb(1'b1, 8'h00, 32'h04);
        wait_period(1'b0);
    endtask
    task automatic t_irq;
        apb(1'b1, 8'h0c, 32'h3);
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b1, 8'h00, 32'h2a);
        trip <= 3'h2;
        repeat (5) @(posedge clock);
        #1 chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b0, 8'h04, 32'h0);
        chk("irq status", 32'h1, rd);
        trip <= 3'h0;
        apb(1'b1, 8'h0c, 32'h1);
        repeat (2) @(posedge clock);
        #1 chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, 8'h00, 32'h2a);
        wait_period(1'b1);
        repeat (2) @(posedge clock);
        #1 chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b0, 8'h04, 32'h0);
        chk("resume status", 32'h2, rd);
    endtask
    task automatic t_mode;
        mode <= 1'b0;
        apb(1'b1, 8'h00, 32'h1a);
        trip <= 3'h4;
        repeat (5) @(posedge clock);
        #1 chk("pins off outside mode", 32'h0, {28'h0, pout.enable});
        apb(1'b0, 8'h00, 32'h0);
        chk("no status outside mode", 32'h1a, rd);
        trip <= 3'h0;
        repeat (4) @(posedge clock);
        mode <= 1'b1;
        @(posedge clock);
        #1 chk("pins in mode", {24'h0, lvl, 4'hf}, {24'h0, pout});
    endtask
    task automatic t_freeze;
        apb(1'b1, 8'h00, 32'h14);
        clk_en <= 1'b0;
        trip   <= 3'h4;
        repeat (5) @(posedge clock);
        #1 chk("pins while frozen", 32'h5f, {24'h0, pout});
        @(posedge clock);
        trip   <= 3'h0;
        repeat (2) @(posedge clock);
        clk_en <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk("status frozen", 32'h14, rd);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        t_regs();
        t_sources();
        t_gate();
        t_hold();
        t_manual();
        t_irq();
        t_mode();
        t_freeze();
        print_verdict();
    end
endmodule
`default_nettype wire
